// File: hdl/cfg_select_consts.vh
// Constants for the strap and register configuration selector
`ifndef CFG_SELECT_CONSTS_VH
`define CFG_SELECT_CONSTS_VH

// Register indices
`define REG_GENERAL 5'h00
`define REG_PATTERN 5'h0A
`define REG_OVERRIDE 5'h0D
`define REG_STRAPCFG 5'h1E
`define REG_STATUS 5'h1F

// Field positions
`define BIT_SOFT_RESET 10
`define BIT_REF_SELECT 5
`define BIT_PDN_GLOBAL 0
`define BIT_OVERRIDE 10
`define BIT_DATA_FORMAT 9
`define PAT_MSB 7
`define PAT_LSB 5
`define BIT_COARSE_GAIN 4
`define BIT_ONE_LANE 0
`define BIT_SINGLE_RATE 1
`define BIT_SER16 2
`define BIT_RISE_EDGE 3
`define BIT_LSB_FIRST 4
`define PDN_CHAN_MSB 4
`define PDN_CHAN_LSB 1
`define STRAP_MSB 4
`define STRAP_LSB 0

// Channel count and serial clock/data pin pair codes
`define NUM_CHANNELS 4
`define PAIR_IDLE 2'h0
`define PAIR_SYNC 2'h1
`define PAIR_PDN 2'h2

// Level codes
`define LVL_GND 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_SUP 2'h3

// Test pattern codes
`define PAT_NORMAL 3'h0
`define PAT_SYNC 3'h1
`define PAT_DESKEW 3'h2

`define DATA_RESET 11'h000
`define PAT_RESET 3'h0
`define STRAP_RESET 5'h00
`define CHAN_RESET 4'h0

`endif

// File: hdl/cfg_select.v
// Strap decode and register priority selection for the converter config
`timescale 1ns/1ps
`include "cfg_select_consts.vh"

module cfg_select (
    input wire clock_i,
    input wire rst_i,
    input wire combined_mode_i,
    input wire pdn_pin_i,
    input wire [1:0] interface_select_strap_i,
    input wire [1:0] serialization_select_strap_i,
    input wire [1:0] reserved_strap_i,
    input wire [1:0] bit_order_format_strap_i,
    input wire [1:0] serial_select_pin_i,
    input wire serial_clock_pin_i,
    input wire serial_data_pin_i,
    input wire [4:0] addr_i,
    input wire [10:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [10:0] rdata_o,
    output reg global_pdn_o,
    output reg [3:0] channel_pdn_o,
    output reg ref_pdn_o,
    output reg pll_pdn_o,
    output reg outbuf_pdn_o,
    output reg internal_ref_o,
    output reg coarse_gain_o,
    output reg [2:0] pattern_o,
    output reg single_rate_o,
    output reg two_lane_o,
    output reg ser16_o,
    output reg rise_edge_o,
    output reg lsb_first_o,
    output reg offset_binary_o
);

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg ref_sel;
reg pdn_global;
reg [3:0] pdn_chan;
reg data_format;
reg [2:0] pat_sel;
reg override;
reg coarse_gain;
reg [4:0] strap_reg;
reg soft_reset_pending;

// A soft reset write restores defaults on the next edge and reads back low
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        ref_sel <= 1'b0;
        pdn_global <= 1'b0;
        pdn_chan <= `CHAN_RESET;
        data_format <= 1'b0;
        pat_sel <= `PAT_RESET;
        override <= 1'b0;
        coarse_gain <= 1'b0;
        strap_reg <= `STRAP_RESET;
        soft_reset_pending <= 1'b0;
    end else if (soft_reset_pending) begin
        ref_sel <= 1'b0;
        pdn_global <= 1'b0;
        pdn_chan <= `CHAN_RESET;
        data_format <= 1'b0;
        pat_sel <= `PAT_RESET;
        override <= 1'b0;
        coarse_gain <= 1'b0;
        strap_reg <= `STRAP_RESET;
        soft_reset_pending <= 1'b0;
    end else if (wr_i) begin
        case (addr_i)
        `REG_GENERAL: begin
            soft_reset_pending <= wdata_i[`BIT_SOFT_RESET];
            ref_sel <= wdata_i[`BIT_REF_SELECT];
            pdn_chan <= wdata_i[`PDN_CHAN_MSB:`PDN_CHAN_LSB];
            pdn_global <= wdata_i[`BIT_PDN_GLOBAL];
        end
        `REG_PATTERN: begin
            data_format <= wdata_i[`BIT_DATA_FORMAT];
            pat_sel <= wdata_i[`PAT_MSB:`PAT_LSB];
        end
        `REG_OVERRIDE: begin
            override <= wdata_i[`BIT_OVERRIDE];
            coarse_gain <= wdata_i[`BIT_COARSE_GAIN];
        end
        `REG_STRAPCFG: begin
            strap_reg <= wdata_i[`STRAP_MSB:`STRAP_LSB];
        end
        default: begin
        end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Strap decode, pure combinational on the level codes

reg s_single_rate;
reg s_two_lane;
reg s_ser16;
reg s_rise;
reg s_lsb;
reg s_offset;
reg s_int_ref;
reg s_gain;
reg [2:0] s_pat;
reg s_pdn;

// Level codes come from the detector, so decode is table lookup only
always @* begin
    case (interface_select_strap_i)
    `LVL_GND: begin
        s_single_rate = 1'b0;
        s_two_lane = 1'b0;
    end
    `LVL_HIGH: begin
        s_single_rate = 1'b1;
        s_two_lane = 1'b1;
    end
    `LVL_SUP: begin
        s_single_rate = 1'b0;
        s_two_lane = 1'b1;
    end
    default: begin
        // Unused half level falls back to the safest one-lane setting
        s_single_rate = 1'b0;
        s_two_lane = 1'b0;
    end
    endcase
    case (serialization_select_strap_i)
    `LVL_GND: begin
        s_ser16 = 1'b0;
        s_rise = 1'b0;
    end
    `LVL_LOW: begin
        s_ser16 = 1'b1;
        s_rise = 1'b0;
    end
    `LVL_HIGH: begin
        s_ser16 = 1'b1;
        s_rise = 1'b1;
    end
    default: begin
        s_ser16 = 1'b0;
        s_rise = 1'b1;
    end
    endcase
    case (bit_order_format_strap_i)
    `LVL_GND: begin
        s_lsb = 1'b0;
        s_offset = 1'b0;
    end
    `LVL_LOW: begin
        s_lsb = 1'b0;
        s_offset = 1'b1;
    end
    `LVL_HIGH: begin
        s_lsb = 1'b1;
        s_offset = 1'b1;
    end
    default: begin
        s_lsb = 1'b1;
        s_offset = 1'b0;
    end
    endcase
    case (serial_select_pin_i)
    `LVL_GND: begin
        s_int_ref = 1'b0;
        s_gain = 1'b0;
    end
    `LVL_LOW: begin
        s_int_ref = 1'b0;
        s_gain = 1'b1;
    end
    `LVL_HIGH: begin
        s_int_ref = 1'b1;
        s_gain = 1'b1;
    end
    default: begin
        s_int_ref = 1'b1;
        s_gain = 1'b0;
    end
    endcase
    case ({serial_clock_pin_i, serial_data_pin_i})
    `PAIR_IDLE: begin
        s_pat = `PAT_NORMAL;
        s_pdn = 1'b0;
    end
    `PAIR_SYNC: begin
        s_pat = `PAT_SYNC;
        s_pdn = 1'b0;
    end
    `PAIR_PDN: begin
        s_pat = `PAT_NORMAL;
        s_pdn = 1'b1;
    end
    default: begin
        s_pat = `PAT_DESKEW;
        s_pdn = 1'b0;
    end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Priority selection

reg next_global_pdn;
reg next_int_ref;
reg next_gain;
reg [2:0] next_pattern;
reg next_single_rate;
reg next_two_lane;
reg next_ser16;
reg next_rise;
reg next_lsb;
reg next_offset;

// Reserved strap is never read by the logic, ignored by design; tie it to ground
always @* begin
    if (override) begin
        next_single_rate = strap_reg[`BIT_SINGLE_RATE];
        next_two_lane = ~strap_reg[`BIT_ONE_LANE];
        next_ser16 = strap_reg[`BIT_SER16];
        next_rise = strap_reg[`BIT_RISE_EDGE];
        next_lsb = strap_reg[`BIT_LSB_FIRST];
        next_offset = data_format;
    end else begin
        next_single_rate = s_single_rate;
        next_two_lane = s_two_lane;
        next_ser16 = s_ser16;
        next_rise = s_rise;
        next_lsb = s_lsb;
        next_offset = s_offset;
    end
    if (combined_mode_i) begin
        // Serial pins carry register traffic, so their levels are ignored
        next_int_ref = ref_sel;
        next_gain = override & coarse_gain;
        next_pattern = pat_sel;
        next_global_pdn = pdn_pin_i | pdn_global;
    end else begin
        next_int_ref = s_int_ref;
        next_gain = s_gain;
        next_pattern = s_pat;
        next_global_pdn = pdn_pin_i | s_pdn;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs

// Global power down fans out to every analog and output block
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        global_pdn_o <= 1'b0;
        ref_pdn_o <= 1'b0;
        pll_pdn_o <= 1'b0;
        outbuf_pdn_o <= 1'b0;
        internal_ref_o <= 1'b0;
        coarse_gain_o <= 1'b0;
        pattern_o <= `PAT_NORMAL;
        single_rate_o <= 1'b0;
        two_lane_o <= 1'b0;
        ser16_o <= 1'b0;
        rise_edge_o <= 1'b0;
        lsb_first_o <= 1'b0;
        offset_binary_o <= 1'b0;
    end else begin
        global_pdn_o <= next_global_pdn;
        ref_pdn_o <= next_global_pdn;
        pll_pdn_o <= next_global_pdn;
        outbuf_pdn_o <= next_global_pdn;
        internal_ref_o <= next_int_ref;
        coarse_gain_o <= next_gain;
        pattern_o <= next_pattern;
        single_rate_o <= next_single_rate;
        two_lane_o <= next_two_lane;
        ser16_o <= next_ser16;
        // Capture edge only means something in two-lane single-rate mode
        rise_edge_o <= next_rise & next_single_rate & next_two_lane;
        lsb_first_o <= next_lsb;
        offset_binary_o <= next_offset;
    end
end

// One flop per channel: each sleeps on its own bit or on global power down
genvar ch;
generate
    for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan_pdn
        always @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                channel_pdn_o[ch] <= 1'b0;
            end else begin
                channel_pdn_o[ch] <= next_global_pdn | pdn_chan[ch];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read port: data valid the cycle after the strobe, zero otherwise

reg [10:0] next_rdata;

// Idle or unmapped cycles return zero, so stale data never lingers
always @* begin
    next_rdata = `DATA_RESET;
    if (rd_i) begin
        case (addr_i)
        `REG_GENERAL: begin
            next_rdata = {5'h00, ref_sel, pdn_chan, pdn_global};
        end
        `REG_PATTERN: begin
            next_rdata = {1'b0, data_format, 1'b0, pat_sel, 5'h00};
        end
        `REG_OVERRIDE: begin
            next_rdata = {override, 5'h00, coarse_gain, 4'h0};
        end
        `REG_STRAPCFG: begin
            next_rdata = {6'h00, strap_reg};
        end
        `REG_STATUS: begin
            // Status shows what the converter really runs with now
            next_rdata = {global_pdn_o, internal_ref_o, coarse_gain_o,
                pattern_o, lsb_first_o, rise_edge_o, ser16_o,
                single_rate_o, two_lane_o};
        end
        default: begin
            next_rdata = `DATA_RESET;
        end
        endcase
    end
end

// Read data register
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        rdata_o <= `DATA_RESET;
    end else begin
        rdata_o <= next_rdata;
    end
end

endmodule // cfg_select

// File: testbench/strap_board.sv
// Board strap model: resistor picks resolved to level codes
`timescale 1ns/1ps
module strap_board (
    input wire [11:0] pick_i,
    output wire [11:0] level_o
);
    // Every strap sits inside its tolerance band, so code equals pick
    assign level_o = pick_i;
endmodule // strap_board

// File: testbench/cfg_select_chk.sv
// Assertions on the configuration selector ports
`timescale 1ns/1ps
module cfg_select_chk (
    input wire clock_i,
    input wire rst_i,
    input wire combined_mode_i,
    input wire pdn_pin_i,
    input wire [1:0] interface_select_strap_i,
    input wire [1:0] serialization_select_strap_i,
    input wire [1:0] bit_order_format_strap_i,
    input wire [1:0] serial_select_pin_i,
    input wire serial_clock_pin_i,
    input wire serial_data_pin_i,
    input wire [4:0] addr_i,
    input wire [10:0] wdata_i,
    input wire wr_i,
    input wire global_pdn_o,
    input wire [3:0] channel_pdn_o,
    input wire ref_pdn_o,
    input wire pll_pdn_o,
    input wire outbuf_pdn_o,
    input wire internal_ref_o,
    input wire coarse_gain_o,
    input wire single_rate_o,
    input wire two_lane_o,
    input wire ser16_o,
    input wire rise_edge_o,
    input wire lsb_first_o,
    input wire offset_binary_o
);
    reg ovr;
    reg srp;
    // Shadow of the override bit; a soft reset clears it one edge late
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ovr <= 1'b0;
            srp <= 1'b0;
        end else if (srp) begin
            ovr <= 1'b0;
            srp <= 1'b0;
        end else if (wr_i && addr_i == 5'h0D) begin
            ovr <= wdata_i[10];
        end else if (wr_i && addr_i == 5'h00) begin
            srp <= wdata_i[10];
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_pin; pdn_pin_i |=> global_pdn_o; endproperty
    a_pin: assert property (p_pin) else $error("pin pdn");
    property p_pdn; !combined_mode_i && serial_clock_pin_i &&
        !serial_data_pin_i |=> global_pdn_o; endproperty
    a_pdn: assert property (p_pdn) else $error("pair pdn");
    property p_all; global_pdn_o |-> &{channel_pdn_o, ref_pdn_o,
        pll_pdn_o, outbuf_pdn_o}; endproperty
    a_all: assert property (p_all) else $error("all pdn");
    property p_sel; !combined_mode_i && serial_select_pin_i == 2'h1
        |=> coarse_gain_o && !internal_ref_o; endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_if; !ovr && !wr_i && interface_select_strap_i == 2'h3
        |=> two_lane_o && !single_rate_o; endproperty
    a_if: assert property (p_if) else $error("if");
    property p_ser; !ovr && !wr_i && serialization_select_strap_i ==
        2'h1 |=> ser16_o && !rise_edge_o; endproperty
    a_ser: assert property (p_ser) else $error("ser");
    property p_ord; !ovr && !wr_i && bit_order_format_strap_i == 2'h2
        |=> lsb_first_o && offset_binary_o; endproperty
    a_ord: assert property (p_ord) else $error("order");
    property p_gain; combined_mode_i && !ovr && !wr_i
        |=> !coarse_gain_o; endproperty
    a_gain: assert property (p_gain) else $error("gain");
endmodule // cfg_select_chk

// File: testbench/tb.sv
// Self-checking testbench for the configuration selector
`timescale 1ns/1ps
module tb;
    logic clock_i = 0, rst_i = 1, combined_mode_i = 0, pdn_pin_i = 0;
    logic wr_i = 0, rd_i = 0;
    logic [4:0] addr_i = 5'h00;
    logic [10:0] wdata_i = 11'h000, got;
    logic [11:0] pick = 12'h000;
    wire [11:0] lvl;
    wire [1:0] interface_select_strap_i, serialization_select_strap_i;
    wire [1:0] reserved_strap_i, bit_order_format_strap_i;
    wire [1:0] serial_select_pin_i;
    wire serial_clock_pin_i, serial_data_pin_i;
    wire [10:0] rdata_o;
    wire [3:0] channel_pdn_o;
    wire [2:0] pattern_o;
    wire global_pdn_o, ref_pdn_o, pll_pdn_o, outbuf_pdn_o, internal_ref_o;
    wire coarse_gain_o, single_rate_o, two_lane_o, ser16_o, rise_edge_o;
    wire lsb_first_o, offset_binary_o;
    int miscompares = 0, checks = 0;
    // Board picks fan out to the strap inputs
    assign {serial_data_pin_i, serial_clock_pin_i, serial_select_pin_i,
        bit_order_format_strap_i, reserved_strap_i,
        serialization_select_strap_i, interface_select_strap_i} = lvl;
    wire [5:0] link = {single_rate_o, two_lane_o, ser16_o, rise_edge_o,
        lsb_first_o, offset_binary_o};
    wire [7:0] pdn = {channel_pdn_o, ref_pdn_o, pll_pdn_o, outbuf_pdn_o,
        global_pdn_o};
    strap_board i_strap_board (.pick_i(pick), .level_o(lvl));
    cfg_select i_cfg_select (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .combined_mode_i(combined_mode_i),
        .pdn_pin_i(pdn_pin_i),
        .interface_select_strap_i(interface_select_strap_i),
        .serialization_select_strap_i(serialization_select_strap_i),
        .reserved_strap_i(reserved_strap_i),
        .bit_order_format_strap_i(bit_order_format_strap_i),
        .serial_select_pin_i(serial_select_pin_i),
        .serial_clock_pin_i(serial_clock_pin_i),
        .serial_data_pin_i(serial_data_pin_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .global_pdn_o(global_pdn_o),
        .channel_pdn_o(channel_pdn_o),
        .ref_pdn_o(ref_pdn_o),
        .pll_pdn_o(pll_pdn_o),
        .outbuf_pdn_o(outbuf_pdn_o),
        .internal_ref_o(internal_ref_o),
        .coarse_gain_o(coarse_gain_o),
        .pattern_o(pattern_o),
        .single_rate_o(single_rate_o),
        .two_lane_o(two_lane_o),
        .ser16_o(ser16_o),
        .rise_edge_o(rise_edge_o),
        .lsb_first_o(lsb_first_o),
        .offset_binary_o(offset_binary_o)
    );
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    task chk(input string n, input [10:0] s, e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    // Outputs lag inputs by one edge; sample after updates land
    task tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task wr(input [4:0] a, input [10:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task rd(input [4:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask
    // Every strap level and pin pair in parallel control
    task t_parallel;
        logic [1:0] i;
        logic [2:0] p;
        logic m, t;
        for (int k = 0; k < 4; k++) begin
            i = k[1:0];
            m = i == 2'h1 || i == 2'h2;
            t = i == 2'h2;
            // Pair code {clk, data} equals i: idle, sync, off, deskew
            p = i[1] ? 3'h2 : {2'h0, i[0]};
            @(posedge clock_i);
            pick <= {i[0], i[1], i, i, 2'h0, i, i};
            tick(3);
            chk("lanes", link[5:3], {t, i[1], m});
            chk("order", link[2:0], {t, i[1], m});
            chk("ref", {internal_ref_o, coarse_gain_o}, {i[1], m});
            chk("pdn", pdn, {8{t}});
            if (!t)
                chk("pat", pattern_o, p);
        end
        @(posedge clock_i);
        pdn_pin_i <= 1'b1;
        tick(3);
        chk("pin", global_pdn_o, 1'b1);
    endtask
    // Registers beside straps, override and soft reset
    task t_combined;
        @(posedge clock_i);
        combined_mode_i <= 1'b1;
        pdn_pin_i <= 1'b0;
        pick <= 12'h7FF;
        wr(5'h00, 11'h400);
        tick(3);
        chk("strap", link, 6'h12);
        chk("pins", {global_pdn_o, pattern_o, internal_ref_o,
            coarse_gain_o}, 6'h00);
        wr(5'h00, 11'h021);
        wr(5'h0A, 11'h220);
        wr(5'h1E, 11'h01E);
        wr(5'h0D, 11'h410);
        tick(3);
        chk("reg", link, 6'h3F);
        chk("regs", {global_pdn_o, pattern_o, internal_ref_o,
            coarse_gain_o}, 6'h27);
        rd(5'h1F);
        chk("status", got, 11'h73F);
        wr(5'h00, 11'h02A);
        tick(3);
        chk("reg pdn", global_pdn_o, 1'b0);
        chk("chan", channel_pdn_o, 4'h5);
        @(posedge clock_i);
        pdn_pin_i <= 1'b1;
        tick(3);
        chk("pin pdn", global_pdn_o, 1'b1);
        rd(5'h05);
        chk("unmapped", got, 11'h000);
        wr(5'h00, 11'h400);
        rd(5'h0D);
        chk("soft", got, 11'h000);
        rd(5'h00);
        chk("self clear", got, 11'h000);
    endtask
    task final_report;
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        t_parallel;
        t_combined;
        final_report;
    end
    // Watchdog: the run needs well under 200 cycles
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
endmodule // tb
bind cfg_select cfg_select_chk i_cfg_select_chk (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .combined_mode_i(combined_mode_i),
    .pdn_pin_i(pdn_pin_i),
    .interface_select_strap_i(interface_select_strap_i),
    .serialization_select_strap_i(serialization_select_strap_i),
    .bit_order_format_strap_i(bit_order_format_strap_i),
    .serial_select_pin_i(serial_select_pin_i),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_data_pin_i(serial_data_pin_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .global_pdn_o(global_pdn_o),
    .channel_pdn_o(channel_pdn_o),
    .ref_pdn_o(ref_pdn_o),
    .pll_pdn_o(pll_pdn_o),
    .outbuf_pdn_o(outbuf_pdn_o),
    .internal_ref_o(internal_ref_o),
    .coarse_gain_o(coarse_gain_o),
    .single_rate_o(single_rate_o),
    .two_lane_o(two_lane_o),
    .ser16_o(ser16_o),
    .rise_edge_o(rise_edge_o),
    .lsb_first_o(lsb_first_o),
    .offset_binary_o(offset_binary_o)
);
